// *** lccr_defs.svh ***
// offsets, field positions and reset values of the lane C/D config bank
`ifndef LCCR_DEFS_SVH
`define LCCR_DEFS_SVH

// register indices; byte address is four times the index
`define LCCR_IDX_DEV_CTRL 5'h00
`define LCCR_IDX_GLOB_CTRL 5'h10
`define LCCR_IDX_LANE_C 5'h12
`define LCCR_IDX_LANE_D 5'h13
`define LCCR_IDX_PIN_STATE 5'h1f

// lane config fields
`define LCCR_F_CTC 11
`define LCCR_F_MFO_HI 10
`define LCCR_F_MFO_LO 9
`define LCCR_F_LOS 8
`define LCCR_F_CFG_HI 7
`define LCCR_F_CFG_LO 6
`define LCCR_F_EMPH_HI 5
`define LCCR_F_EMPH_LO 4
`define LCCR_F_LOOP 3
`define LCCR_F_PATTERN 2
`define LCCR_F_COMMA 1
`define LCCR_F_PDOWN 0

// device control bits that act on every lane
`define LCCR_F_DEV_LOOP 14
`define LCCR_F_DEV_PDOWN 11

// writable bits and reset values
`define LCCR_LANE_MASK 16'h0fff
`define LCCR_LANE_RST 16'h0102
`define LCCR_GLOB_MASK 16'h0fff
`define LCCR_GLOB_RST 16'h0102
`define LCCR_DEV_MASK 16'h4800
`define LCCR_DEV_RST 16'h0000

// pin state register bits
`define LCCR_P_STRAP_LO 0
`define LCCR_P_STRAP_HI 1
`define LCCR_P_PATTERN 2
`define LCCR_P_ALIGN 3
`define LCCR_P_IO_STD 4

// multifunction output select codes
`define LCCR_MFO_IO_STD 2'h0
`define LCCR_MFO_COMMA 2'h1
`define LCCR_MFO_LOS 2'h2
`define LCCR_MFO_PATTERN 2'h3

`endif

// *** lccr_lane.sv ***
// one lane config register and its effective controls
`timescale 1ns/1ps
`include "lccr_defs.svh"
module lccr_lane (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] glob_ctrl,
  input wire logic dev_loop,
  input wire logic dev_pdown,
  input wire logic strap_hi,
  input wire logic strap_lo,
  input wire logic pattern_pin,
  input wire logic align_pin,
  input wire logic io_std,
  input wire logic comma_det,
  input wire logic los_stat,
  input wire logic pattern_ok,
  output logic [15:0] cfg,
  output logic multi_func_out,
  output logic ctc_en,
  output logic los_det_en,
  output logic [1:0] mode_cfg,
  output logic emph_sel_hi,
  output logic emph_sel_lo,
  output logic loopback_en,
  output logic pattern_en,
  output logic comma_align_en,
  output logic power_down
);
  import lccr_pkg::*;

  logic [15:0] next_cfg;
  logic [1:0] mfo_sel;

  // strap-locked bits keep their value while the pin is high
  always_comb begin
    next_cfg = cfg;
    if (wr_en) begin
      next_cfg = wr_data & `LCCR_LANE_MASK;
      if (strap_hi) begin
        next_cfg[`LCCR_F_CFG_HI] = cfg[`LCCR_F_CFG_HI];
      end
      if (strap_lo) begin
        next_cfg[`LCCR_F_CFG_LO] = cfg[`LCCR_F_CFG_LO];
      end
      if (pattern_pin) begin
        next_cfg[`LCCR_F_PATTERN] = cfg[`LCCR_F_PATTERN];
      end
    end
  end

  // stored register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `LCCR_LANE_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // select merges lane field with the global field
  assign mfo_sel = cfg[`LCCR_F_MFO_HI:`LCCR_F_MFO_LO]
    | glob_ctrl[`LCCR_F_MFO_HI:`LCCR_F_MFO_LO];

  // multifunction pin, registered so the pin never glitches
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      multi_func_out <= 1'b0;
    end else begin
      case (mfo_sel)
        `LCCR_MFO_IO_STD: multi_func_out <= io_std;
        `LCCR_MFO_COMMA: multi_func_out <= comma_det;
        `LCCR_MFO_LOS: multi_func_out <= los_stat;
        `LCCR_MFO_PATTERN: multi_func_out <= pattern_ok;
        default: multi_func_out <= 1'b0;
      endcase
    end
  end

  // effective controls, combined with global and device bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctc_en <= 1'b0;
      los_det_en <= 1'b0;
      mode_cfg <= 2'h0;
      emph_sel_hi <= 1'b0;
      emph_sel_lo <= 1'b0;
      loopback_en <= 1'b0;
      pattern_en <= 1'b0;
      comma_align_en <= 1'b0;
      power_down <= 1'b0;
    end else begin
      ctc_en <= cfg[`LCCR_F_CTC] | glob_ctrl[`LCCR_F_CTC];
      los_det_en <= cfg[`LCCR_F_LOS] & glob_ctrl[`LCCR_F_LOS];
      mode_cfg <= cfg[`LCCR_F_CFG_HI:`LCCR_F_CFG_LO]
        | glob_ctrl[`LCCR_F_CFG_HI:`LCCR_F_CFG_LO];
      emph_sel_hi <= cfg[`LCCR_F_EMPH_HI] | glob_ctrl[`LCCR_F_EMPH_HI];
      emph_sel_lo <= cfg[`LCCR_F_EMPH_LO] | glob_ctrl[`LCCR_F_EMPH_LO];
      loopback_en <= cfg[`LCCR_F_LOOP] | dev_loop;
      pattern_en <= cfg[`LCCR_F_PATTERN]
        | glob_ctrl[`LCCR_F_PATTERN];
      comma_align_en <= cfg[`LCCR_F_COMMA] & align_pin
        & glob_ctrl[`LCCR_F_COMMA];
      power_down <= cfg[`LCCR_F_PDOWN] | dev_pdown;
    end
  end
endmodule

// *** lccr_pkg.sv ***
// types shared by the lane C/D config bank
package lccr_pkg;

  // bus slave states, one-hot
  typedef enum logic [3:0] {
    LCCR_ST_IDLE = 4'h1,
    LCCR_ST_WR = 4'h2,
    LCCR_ST_RWAIT = 4'h4,
    LCCR_ST_RD = 4'h8
  } lccr_state_t;

endpackage

// *** lccr_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lccr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import lccr_pkg::*;

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// *** lccr_top.sv ***
// ahb-lite register bank for the lane C and lane D configuration
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lccr_defs.svh"
module lccr_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic mode_strap_hi,
  input wire logic mode_strap_lo,
  input wire logic pattern_test_pin,
  input wire logic align_enable_pin,
  input wire logic io_std_hstl,
  input wire logic comma_det_c,
  input wire logic comma_det_d,
  input wire logic signal_lost_c,
  input wire logic signal_lost_d,
  input wire logic pattern_check_ok_c,
  input wire logic pattern_check_ok_d,
  output logic multi_func_out_c,
  output logic ctc_en_c,
  output logic los_det_en_c,
  output logic [1:0] mode_cfg_c,
  output logic emph_sel_hi_c,
  output logic emph_sel_lo_c,
  output logic loopback_en_c,
  output logic pattern_en_c,
  output logic comma_align_en_c,
  output logic power_down_c,
  output logic multi_func_out_d,
  output logic ctc_en_d,
  output logic los_det_en_d,
  output logic [1:0] mode_cfg_d,
  output logic emph_sel_hi_d,
  output logic emph_sel_lo_d,
  output logic loopback_en_d,
  output logic pattern_en_d,
  output logic comma_align_en_d,
  output logic power_down_d
);
  import lccr_pkg::*;

  lccr_state_t state;
  lccr_state_t next_state;
  logic take;
  logic [4:0] addr_idx;
  logic addr_hit;
  logic wr_c;
  logic wr_d;
  logic wr_glob;
  logic wr_dev;
  logic [15:0] glob_ctrl;
  logic [15:0] dev_ctrl;
  logic [15:0] cfg_c;
  logic [15:0] cfg_d;
  logic [4:0] pins_async;
  logic [4:0] pins_q;
  logic [15:0] pin_state;
  logic [15:0] rd_word;
  logic size_word;

  // pins are asynchronous to core_clk
  assign pins_async = {io_std_hstl, align_enable_pin, pattern_test_pin,
                       mode_strap_hi, mode_strap_lo};

  lccr_sync #(
    .W(5)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_async),
    .sync_out(pins_q)
  );

  // read-only view of the synchronised pins
  always_comb begin
    pin_state = 16'h0000;
    pin_state[`LCCR_P_STRAP_LO] = pins_q[`LCCR_P_STRAP_LO];
    pin_state[`LCCR_P_STRAP_HI] = pins_q[`LCCR_P_STRAP_HI];
    pin_state[`LCCR_P_PATTERN] = pins_q[`LCCR_P_PATTERN];
    pin_state[`LCCR_P_ALIGN] = pins_q[`LCCR_P_ALIGN];
    pin_state[`LCCR_P_IO_STD] = pins_q[`LCCR_P_IO_STD];
  end

  // a transfer is taken on a selected nonseq/seq address phase
  assign take = hsel & hready & htrans[1];
  // narrower sizes still land on the whole word
  assign size_word = (hsize == 3'h2);

  // address phase capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_idx <= 5'h00;
      addr_hit <= 1'b0;
    end else if (take) begin
      addr_idx <= haddr[6:2];
      addr_hit <= (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'h0);
    end
  end

  // slave sequencer: reads take one wait state so that a read right
  // behind a write always sees the written value
  always_comb begin
    next_state = state;
    case (state)
      LCCR_ST_IDLE, LCCR_ST_WR, LCCR_ST_RD: begin
        if (take && hwrite) begin
          next_state = LCCR_ST_WR;
        end else if (take) begin
          next_state = LCCR_ST_RWAIT;
        end else begin
          next_state = LCCR_ST_IDLE;
        end
      end
      LCCR_ST_RWAIT: begin
        next_state = LCCR_ST_RD;
      end
      default: begin
        next_state = LCCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LCCR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ready drops only for the read wait state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= (next_state != LCCR_ST_RWAIT);
    end
  end

  // response is always okay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // write strobes in the write data phase; unmapped writes vanish
  assign wr_c = (state == LCCR_ST_WR) & addr_hit
    & (addr_idx == `LCCR_IDX_LANE_C);
  assign wr_d = (state == LCCR_ST_WR) & addr_hit
    & (addr_idx == `LCCR_IDX_LANE_D);
  assign wr_glob = (state == LCCR_ST_WR) & addr_hit
    & (addr_idx == `LCCR_IDX_GLOB_CTRL);
  assign wr_dev = (state == LCCR_ST_WR) & addr_hit
    & (addr_idx == `LCCR_IDX_DEV_CTRL);

  // global lane control, shared by both lanes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      glob_ctrl <= `LCCR_GLOB_RST;
    end else if (wr_glob) begin
      glob_ctrl <= hwdata[15:0] & `LCCR_GLOB_MASK;
    end
  end

  // device control: only loopback and power-down bits live here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctrl <= `LCCR_DEV_RST;
    end else if (wr_dev) begin
      dev_ctrl <= hwdata[15:0] & `LCCR_DEV_MASK;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (addr_hit) begin
      case (addr_idx)
        `LCCR_IDX_DEV_CTRL: rd_word = dev_ctrl;
        `LCCR_IDX_GLOB_CTRL: rd_word = glob_ctrl;
        `LCCR_IDX_LANE_C: rd_word = cfg_c;
        `LCCR_IDX_LANE_D: rd_word = cfg_d;
        `LCCR_IDX_PIN_STATE: rd_word = pin_state;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // read data captured at the end of the wait state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (state == LCCR_ST_RWAIT) begin
      hrdata <= {16'h0000, rd_word};
    end
  end

  // lane C: its config bits 10:9, ORed with global bits 10:9, feed its output select
  lccr_lane u_lane_c (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_c),
    .wr_data(hwdata[15:0]),
    .glob_ctrl(glob_ctrl),
    .dev_loop(dev_ctrl[`LCCR_F_DEV_LOOP]),
    .dev_pdown(dev_ctrl[`LCCR_F_DEV_PDOWN]),
    .strap_hi(pins_q[`LCCR_P_STRAP_HI]),
    .strap_lo(pins_q[`LCCR_P_STRAP_LO]),
    .pattern_pin(pins_q[`LCCR_P_PATTERN]),
    .align_pin(pins_q[`LCCR_P_ALIGN]),
    .io_std(pins_q[`LCCR_P_IO_STD]),
    .comma_det(comma_det_c),
    .los_stat(signal_lost_c),
    .pattern_ok(pattern_check_ok_c),
    .cfg(cfg_c),
    .multi_func_out(multi_func_out_c),
    .ctc_en(ctc_en_c),
    .los_det_en(los_det_en_c),
    .mode_cfg(mode_cfg_c),
    .emph_sel_hi(emph_sel_hi_c),
    .emph_sel_lo(emph_sel_lo_c),
    .loopback_en(loopback_en_c),
    .pattern_en(pattern_en_c),
    .comma_align_en(comma_align_en_c),
    .power_down(power_down_c)
  );

  // lane D: its config bits 10:9, ORed with global bits 10:9, feed its output select
  lccr_lane u_lane_d (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(wr_d),
    .wr_data(hwdata[15:0]),
    .glob_ctrl(glob_ctrl),
    .dev_loop(dev_ctrl[`LCCR_F_DEV_LOOP]),
    .dev_pdown(dev_ctrl[`LCCR_F_DEV_PDOWN]),
    .strap_hi(pins_q[`LCCR_P_STRAP_HI]),
    .strap_lo(pins_q[`LCCR_P_STRAP_LO]),
    .pattern_pin(pins_q[`LCCR_P_PATTERN]),
    .align_pin(pins_q[`LCCR_P_ALIGN]),
    .io_std(pins_q[`LCCR_P_IO_STD]),
    .comma_det(comma_det_d),
    .los_stat(signal_lost_d),
    .pattern_ok(pattern_check_ok_d),
    .cfg(cfg_d),
    .multi_func_out(multi_func_out_d),
    .ctc_en(ctc_en_d),
    .los_det_en(los_det_en_d),
    .mode_cfg(mode_cfg_d),
    .emph_sel_hi(emph_sel_hi_d),
    .emph_sel_lo(emph_sel_lo_d),
    .loopback_en(loopback_en_d),
    .pattern_en(pattern_en_d),
    .comma_align_en(comma_align_en_d),
    .power_down(power_down_d)
  );
endmodule

// *** lccr_top_asserts.sv ***
// concurrent checks on the ports of the lane C/D config bank
`timescale 1ns/1ps
module lccr_top_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic align_enable_pin,
  input wire logic comma_align_en_c,
  input wire logic comma_align_en_d
);
  logic rd_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // a transfer is taken only with select, ready and an active type
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_take;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  // a read ends with one wait state, then the data cycle
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  // remembers that a read was taken, so a stall can be traced to it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      rd_q <= 1'b0;
    else
      rd_q <= hsel && hready && htrans[1] && !hwrite;
  end

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (rd_take |=> rd_answer)
    else $error("read wait state wrong");
  write_nowait_a: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  stall_cause_a: assert property (!hreadyout |-> rd_q)
    else $error("stall without a read");
  rdata_hold_a: assert property ($past(hreadyout) && hreadyout
    |-> $stable(hrdata))
    else $error("read data moved outside a read");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  lane_top_a: assert property (rd_take ##0 (haddr[7:0] == 8'h48
    || haddr[7:0] == 8'h4c) |=> rd_answer ##0 hrdata[15:12] == 4'h0)
    else $error("lane reserved bits not zero");
  unmapped_zero_a: assert property (rd_take ##0 haddr == 32'h44
    |=> rd_answer ##0 hrdata == 32'h0)
    else $error("unmapped read not zero");
  align_gate_a: assert property (comma_align_en_c
    || comma_align_en_d |-> $past(align_enable_pin, 3))
    else $error("comma align on with pin low");
endmodule

bind lccr_top lccr_top_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .align_enable_pin(align_enable_pin), .comma_align_en_c(comma_align_en_c),
  .comma_align_en_d(comma_align_en_d));

// *** test_lane_cd_config_registers.sv ***
// self-checking bench for the lane C/D config bank
`timescale 1ns/1ps
module test_lane_cd_config_registers;
  logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic mode_strap_hi, mode_strap_lo, pattern_test_pin, align_enable_pin;
  logic io_std_hstl, comma_det_c, comma_det_d, signal_lost_c, signal_lost_d;
  logic pattern_check_ok_c, pattern_check_ok_d;
  logic multi_func_out_c, ctc_en_c, los_det_en_c, emph_sel_hi_c;
  logic emph_sel_lo_c, loopback_en_c, pattern_en_c, comma_align_en_c;
  logic power_down_c, multi_func_out_d, ctc_en_d, los_det_en_d;
  logic emph_sel_hi_d, emph_sel_lo_d, loopback_en_d, pattern_en_d;
  logic comma_align_en_d, power_down_d;
  logic [1:0] mode_cfg_c, mode_cfg_d, code;
  logic [3:0] v;
  int mismatches, checks;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  lccr_top dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .mode_strap_hi,
    .mode_strap_lo, .pattern_test_pin, .align_enable_pin, .io_std_hstl,
    .comma_det_c, .comma_det_d, .signal_lost_c, .signal_lost_d,
    .pattern_check_ok_c, .pattern_check_ok_d, .multi_func_out_c, .ctc_en_c,
    .los_det_en_c, .mode_cfg_c, .emph_sel_hi_c, .emph_sel_lo_c,
    .loopback_en_c, .pattern_en_c, .comma_align_en_c, .power_down_c,
    .multi_func_out_d, .ctc_en_d, .los_det_en_d, .mode_cfg_d,
    .emph_sel_hi_d, .emph_sel_lo_d, .loopback_en_d, .pattern_en_d,
    .comma_align_en_d, .power_down_d);

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // entered just after an edge; the data phase drives idle, so the next address phase never overlaps it
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input string n, input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd_v);
  endtask

  // pins pass two sync flops and an output register
  task automatic wt;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic pins(input logic p);
    mode_strap_hi <= p;
    mode_strap_lo <= p;
    pattern_test_pin <= p;
    wt;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // run needs well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    close_out;
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {mode_strap_hi, mode_strap_lo, pattern_test_pin, io_std_hstl} = '0;
    {comma_det_c, comma_det_d, signal_lost_c, signal_lost_d} = '0;
    {pattern_check_ok_c, pattern_check_ok_d} = '0;
    align_enable_pin = 1'b1;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    wt;
    rc("lane_c", 32'h48, 32'h0102);
    rc("lane_d", 32'h4c, 32'h0102);
    chk("los_c", 1, los_det_en_c);
    chk("comma_c", 1, comma_align_en_c);
    rc("unmapped", 32'h44, 32'h0);
    rc("misaligned", 32'h4a, 32'h0);
    wr(32'h48, 32'hffff);
    rc("lane_c", 32'h48, 32'h0fff);
    rc("lane_d", 32'h4c, 32'h0102);
    wt;
    chk("ctc_c", 1, ctc_en_c);
    chk("mode_c", 3, mode_cfg_c);
    chk("emph_c", 1, emph_sel_hi_c & emph_sel_lo_c);
    chk("loop_c", 1, loopback_en_c);
    chk("pat_c", 1, pattern_en_c);
    chk("pdown_c", 1, power_down_c);
    chk("ctc_d", 0, ctc_en_d);
    wr(32'h48, 32'h0);
    wt;
    chk("los_c", 0, los_det_en_c);
    chk("comma_c", 0, comma_align_en_c);
    chk("ctc_c", 0, ctc_en_c);
    // global bits: OR fields set except the low MFO bit, AND fields cleared
    wr(32'h40, 32'hfcf4);
    rc("glob", 32'h40, 32'h0cf4);
    wr(32'h48, 32'h0102);
    wt;
    chk("ctc_c", 1, ctc_en_c);
    chk("mode_d", 3, mode_cfg_d);
    chk("emph_d", 1, emph_sel_hi_d & emph_sel_lo_d);
    chk("pat_d", 1, pattern_en_d);
    chk("los_d", 0, los_det_en_d);
    chk("comma_d", 0, comma_align_en_d);
    wr(32'h40, 32'h0102);
    wr(32'h0, 32'hffff);
    wt;
    chk("dev_d", 3, {loopback_en_d, power_down_d});
    rc("dev", 32'h0, 32'h4800);
    wr(32'h0, 32'h0);
    // locked bits keep their stored value, whether 0 or 1
    pins(1'b1);
    wr(32'h4c, 32'h01c6);
    rc("locked", 32'h4c, 32'h0102);
    rc("pin_state", 32'h7c, 32'h000f);
    pins(1'b0);
    wr(32'h4c, 32'h01c6);
    rc("unlocked", 32'h4c, 32'h01c6);
    pins(1'b1);
    wr(32'h4c, 32'h0102);
    rc("kept", 32'h4c, 32'h01c6);
    pins(1'b0);
    wr(32'h4c, 32'h0102);
    align_enable_pin <= 1'b0;
    wt;
    chk("comma_pin", 0, comma_align_en_d);
    align_enable_pin <= 1'b1;
    // lane D comma, LOS and pattern sources are inverted so a swapped lane shows up
    for (int k = 0; k < 8; k++) begin
      v = k[0] ? 4'ha : 4'h5;
      code = k[2:1];
      io_std_hstl <= v[0];
      {pattern_check_ok_c, signal_lost_c, comma_det_c} <= v[3:1];
      {pattern_check_ok_d, signal_lost_d, comma_det_d} <= ~v[3:1];
      wr(32'h48, {21'h0, code, 9'h102});
      wr(32'h4c, {21'h0, code, 9'h102});
      wt;
      chk("mfo_c", v[code], multi_func_out_c);
      chk("mfo_d", code == 2'h0 ? v[0] : !v[code], multi_func_out_d);
    end
    wr(32'h40, 32'h0302);
    wr(32'h48, 32'h0502);
    wt;
    chk("mfo_or", v[3], multi_func_out_c);
    close_out;
  end
endmodule
